// File: cal_bus_if.sv
// Interface between the register bank and the calibration register store
`timescale 1ns/100ps
interface cal_bus_if;
    import radio_regs_pkg::*;
    logic wr; // Unlocked write strobe
    logic sel; // Selects second calibration register
    byte_type wdata; // Write data
    byte_type rdata; // Registered read data
    logic clear; // Soft reset to defaults

    modport bank
    (
        output wr,
        output sel,
        output wdata,
        output clear,
        input rdata
    );

    modport store
    (
        input wr,
        input sel,
        input wdata,
        input clear,
        output rdata
    );
endinterface : cal_bus_if

// File: cal_store.sv
// Two-word calibration register store with registered read data
`timescale 1ns/100ps
module cal_store
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    cal_bus_if.store bus
);
    import radio_regs_pkg::*;

    // ==========================================================
    // Storage
    byte_type mem [2]; // Calibration words
    byte_type next_mem [2]; // Next words
    byte_type next_rdata; // Next read data

    // Write, soft clear and read selection
    always_comb
    begin
        next_mem = mem;
        if (bus.clear)
        begin
            next_mem[0] = CAL_REG0_RESET;
            next_mem[1] = CAL_REG1_RESET;
        end
        else if (bus.wr)
        begin
            next_mem[bus.sel] = bus.wdata;
        end
        next_rdata = mem[bus.sel];
    end

    // Register words and read data
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mem[0] <= CAL_REG0_RESET;
            mem[1] <= CAL_REG1_RESET;
            bus.rdata <= 8'h00;
        end
        else if (ce)
        begin
            mem <= next_mem;
            bus.rdata <= next_rdata;
        end
    end

endmodule : cal_store

// File: radio_env_model.sv
// Model of the power sequencing and identity source around the register bank
`timescale 1ns/100ps
module radio_env_model
#(
    parameter logic [31:0] ID_VALUE = 32'hA1B2C3D4, // Arbitrary identity value
    parameter int READY_DELAY = 3 // Cycles from pin release to readiness
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic power_req,
    output logic power_down_pin,
    output logic device_ready,
    output logic [31:0] mfg_id
);
    // ==========================================================
    // Power sequencing
    int cnt; // Cycles of power request, held once it reaches READY_DELAY

    // Identity bytes are fixed
    assign mfg_id = ID_VALUE;

    // Pin follows the request; readiness comes some cycles later
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt <= 0;
            power_down_pin <= 1'b1;
            device_ready <= 1'b0;
        end
        else
        begin
            power_down_pin <= !power_req;
            cnt <= power_req ? ((cnt < READY_DELAY) ? cnt + 1 : cnt) : 0;
            device_ready <= power_req && (cnt >= READY_DELAY);
        end
    end
endmodule : radio_env_model

// File: radio_regs_pkg.sv
// Package with offsets, field positions, reset values and types of the radio control registers
package radio_regs_pkg;

    // ==========================================================
    // Register offsets on the host register port
    localparam logic [5:0] WAKE_IRQ_ENABLE_ADDR = 6'h1C;
    localparam logic [5:0] WAKE_IRQ_STATUS_ADDR = 6'h1D;
    localparam logic [5:0] ANALOG_CONTROL_ADDR = 6'h20;
    localparam logic [5:0] SYNTH_CHANNEL_ADDR = 6'h21;
    localparam logic [5:0] CAL_REG0_ADDR = 6'h2E;
    localparam logic [5:0] CAL_REG1_ADDR = 6'h2F;
    localparam logic [5:0] MFG_ID_FIRST_ADDR = 6'h3C;
    localparam logic [5:0] MFG_ID_LAST_ADDR = 6'h3F;

    // ==========================================================
    // Field positions
    localparam int WAKE_ENABLE_BIT = 0;
    localparam int WAKE_PENDING_BIT = 0;
    localparam int CAL_UNLOCK_BIT = 6;
    localparam int MFG_READ_BIT = 5;
    localparam int AMP_ENABLE_BIT = 2;
    localparam int AMP_INVERT_BIT = 1;
    localparam int SOFT_RESET_BIT = 0;
    localparam int CHANNEL_WIDTH = 7;

    // ==========================================================
    // Values after reset
    localparam logic [7:0] WAKE_IRQ_ENABLE_RESET = 8'h00;
    localparam logic [7:0] WAKE_IRQ_STATUS_RESET = 8'h01;
    localparam logic [7:0] ANALOG_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SYNTH_CHANNEL_RESET = 8'h00;
    localparam logic [7:0] CAL_REG0_RESET = 8'h00;
    localparam logic [7:0] CAL_REG1_RESET = 8'h00;

    // Writable bits of the analog control register (self-clearing bit excluded)
    localparam logic [7:0] ANALOG_CONTROL_MASK = 8'h66;

    // ==========================================================
    // Types
    typedef logic [7:0] byte_type;
    typedef logic [5:0] addr_type;

endpackage : radio_regs_pkg

// File: radio_wake_analog_channel_regs.sv
// Wake, analog control and channel registers of the radio transceiver
//
// Behaviour
// - Enabled wake source fires when powered up and ready
// - Wake condition sets the pending status bit
// - Status read clears pending; status ignores writes
// - Unlock bit gates writes to calibration registers
// - Manufacturing ID reads only while read bit set
// - Amplifier enable bit enables control pin
// - Invert bit selects amplifier pin polarity
// - Soft reset bit restores defaults, self-clears
// - Channel field sets synthesizer in 1 MHz steps
`timescale 1ns/100ps
module radio_wake_analog_channel_regs
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire radio_regs_pkg::addr_type reg_addr,
    input wire radio_regs_pkg::byte_type reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output radio_regs_pkg::byte_type reg_rdata,
    output logic reg_rvalid,
    input wire logic power_down_pin,
    input wire logic device_ready,
    input wire logic [31:0] mfg_id,
    input wire logic amp_tx_active,
    output logic mfg_id_power,
    output logic ext_amp_control_pin,
    output logic ext_amp_control_oe,
    output logic [6:0] synth_channel,
    output logic wake_irq
);
    import radio_regs_pkg::*;

    // ==========================================================
    // Address decoding
    function automatic logic is_cal_addr(input addr_type a);
        is_cal_addr = (a == CAL_REG0_ADDR) || (a == CAL_REG1_ADDR);
    endfunction : is_cal_addr

    function automatic logic is_mfg_addr(input addr_type a);
        is_mfg_addr = (a >= MFG_ID_FIRST_ADDR) && (a <= MFG_ID_LAST_ADDR);
    endfunction : is_mfg_addr

    // ==========================================================
    // Register state
    logic wake_enable; // Wake source enable
    logic wake_pending; // Wake interrupt pending
    byte_type analog_control; // Analog control, self-clearing bit kept zero
    logic [6:0] channel; // Synthesizer channel field
    logic ready_prev; // Previous powered-and-ready level
    logic next_wake_enable;
    logic next_wake_pending;
    byte_type next_analog_control;
    logic [6:0] next_channel;
    logic ready_now; // Powered up and ready for transactions
    logic wake_event; // One-cycle wake condition
    logic soft_reset; // Write of the reset bit
    logic amp_enable; // Amplifier pin enabled
    logic amp_invert; // Amplifier pin active low

    // Manufacturing ID bytes, lowest address holds the low byte
    byte_type mfg_byte [4];
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_mfg
            assign mfg_byte[gi] = mfg_id[8 * gi +: 8];
        end
    endgenerate

    cal_bus_if cal_bus ();

    // Calibration store
    cal_store u_cal_store
    (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .bus(cal_bus.store)
    );

    assign ready_now = !power_down_pin && device_ready;
    assign amp_enable = analog_control[AMP_ENABLE_BIT];
    assign amp_invert = analog_control[AMP_INVERT_BIT];
    assign soft_reset = reg_wr && (reg_addr == ANALOG_CONTROL_ADDR) && reg_wdata[SOFT_RESET_BIT];
    assign wake_event = ready_now && !ready_prev && wake_enable;

    // Calibration writes pass only while unlocked
    assign cal_bus.wr = reg_wr && is_cal_addr(reg_addr) && analog_control[CAL_UNLOCK_BIT];
    assign cal_bus.sel = (reg_addr == CAL_REG1_ADDR);
    assign cal_bus.wdata = reg_wdata;
    assign cal_bus.clear = soft_reset;

    // ==========================================================
    // Next register values
    always_comb
    begin
        next_wake_enable = wake_enable;
        next_wake_pending = wake_pending;
        next_analog_control = analog_control;
        next_channel = channel;
        if (soft_reset)
        begin
            // Device reset restores every default
            next_wake_enable = WAKE_IRQ_ENABLE_RESET[WAKE_ENABLE_BIT];
            next_wake_pending = WAKE_IRQ_STATUS_RESET[WAKE_PENDING_BIT];
            next_analog_control = ANALOG_CONTROL_RESET;
            next_channel = SYNTH_CHANNEL_RESET[6:0];
        end
        else
        begin
            if (reg_wr && (reg_addr == WAKE_IRQ_ENABLE_ADDR))
            begin
                next_wake_enable = reg_wdata[WAKE_ENABLE_BIT];
            end
            if (reg_wr && (reg_addr == ANALOG_CONTROL_ADDR))
            begin
                // Reset bit is never stored, so it reads back zero
                next_analog_control = reg_wdata & ANALOG_CONTROL_MASK;
            end
            if (reg_wr && (reg_addr == SYNTH_CHANNEL_ADDR))
            begin
                next_channel = reg_wdata[6:0];
            end
            // Status ignores writes; a read clears, a new event wins
            if (reg_rd && (reg_addr == WAKE_IRQ_STATUS_ADDR))
            begin
                next_wake_pending = 1'b0;
            end
            if (wake_event)
            begin
                next_wake_pending = 1'b1;
            end
        end
    end

    // Register the control state
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wake_enable <= WAKE_IRQ_ENABLE_RESET[WAKE_ENABLE_BIT];
            wake_pending <= WAKE_IRQ_STATUS_RESET[WAKE_PENDING_BIT];
            analog_control <= ANALOG_CONTROL_RESET;
            channel <= SYNTH_CHANNEL_RESET[6:0];
            // Edge detector starts high so a level already true after reset raises no event
            ready_prev <= 1'b1;
        end
        else if (ce)
        begin
            wake_enable <= next_wake_enable;
            wake_pending <= next_wake_pending;
            analog_control <= next_analog_control;
            channel <= next_channel;
            ready_prev <= ready_now;
        end
    end

    // ==========================================================
    // Read path: stage one picks local data, stage two adds the store
    byte_type rd_local; // Local read value
    logic rd_from_cal; // Answer comes from the store
    logic rd_busy; // Read in flight
    byte_type next_rd_local;
    logic next_rd_from_cal;
    logic next_rd_busy;
    byte_type next_reg_rdata;
    logic next_reg_rvalid;

    // Stage one decode
    always_comb
    begin
        next_rd_local = 8'h00;
        next_rd_from_cal = reg_rd && is_cal_addr(reg_addr);
        next_rd_busy = reg_rd;
        if (is_mfg_addr(reg_addr))
        begin
            // Manufacturing ID hidden unless the read bit is set
            next_rd_local = analog_control[MFG_READ_BIT] ? mfg_byte[reg_addr[1:0]] : 8'h00;
        end
        else
        begin
            case (reg_addr)
                WAKE_IRQ_ENABLE_ADDR: next_rd_local = {7'h00, wake_enable};
                WAKE_IRQ_STATUS_ADDR: next_rd_local = {7'h00, wake_pending};
                ANALOG_CONTROL_ADDR: next_rd_local = analog_control;
                SYNTH_CHANNEL_ADDR: next_rd_local = {1'b0, channel};
                default: next_rd_local = 8'h00; // Unmapped reads as zero
            endcase
        end
        next_reg_rdata = rd_from_cal ? cal_bus.rdata : rd_local;
        next_reg_rvalid = rd_busy;
    end

    // Register the read pipeline
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_local <= 8'h00;
            rd_from_cal <= 1'b0;
            rd_busy <= 1'b0;
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else if (ce)
        begin
            rd_local <= next_rd_local;
            rd_from_cal <= next_rd_from_cal;
            rd_busy <= next_rd_busy;
            reg_rdata <= next_reg_rdata;
            reg_rvalid <= next_reg_rvalid;
        end
    end

    // ==========================================================
    // Pin outputs
    logic next_pin;
    logic next_oe;
    logic next_irq;

    // Amplifier pin, its output enable and wake interrupt
    always_comb
    begin
        // A disabled pin rests low so the external amplifier stays off
        next_oe = amp_enable;
        next_pin = amp_enable ? (amp_tx_active ^ amp_invert) : 1'b0;
        next_irq = wake_pending && wake_enable;
    end

    // Register the pins
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ext_amp_control_pin <= 1'b0;
            ext_amp_control_oe <= 1'b0;
            synth_channel <= SYNTH_CHANNEL_RESET[6:0];
            wake_irq <= 1'b0;
            mfg_id_power <= 1'b0;
        end
        else if (ce)
        begin
            ext_amp_control_pin <= next_pin;
            ext_amp_control_oe <= next_oe;
            synth_channel <= channel;
            wake_irq <= next_irq;
            mfg_id_power <= analog_control[MFG_READ_BIT];
        end
    end

    // ==========================================================
    // Checks
    // Properties sample on the rising edge and rest while reset is low
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Wake source and status register
    wake_set_a: assert property (ce && wake_event |=> wake_pending) else $error("wake event lost");
    wake_gate_a: assert property (ce && !wake_enable && !soft_reset
        && !(reg_rd && reg_addr == WAKE_IRQ_STATUS_ADDR) |=> wake_pending == $past(wake_pending))
        else $error("pending set while disabled");
    status_clear_a: assert property (ce && reg_rd && reg_addr == WAKE_IRQ_STATUS_ADDR && !wake_event
        && !soft_reset |=> !wake_pending) else $error("status read did not clear");
    status_ro_a: assert property (ce && reg_wr && reg_addr == WAKE_IRQ_STATUS_ADDR && !wake_pending
        && !wake_event |=> !wake_pending) else $error("status write set pending");

    // Calibration lock and identity gating
    cal_lock_a: assert property (ce && reg_wr && is_cal_addr(reg_addr) && !analog_control[CAL_UNLOCK_BIT] |=>
        u_cal_store.mem[0] == $past(u_cal_store.mem[0]) && u_cal_store.mem[1] == $past(u_cal_store.mem[1]))
        else $error("locked write passed");
    mfg_gate_a: assert property (ce && reg_rd && is_mfg_addr(reg_addr) && !analog_control[MFG_READ_BIT]
        ##1 ce |=> reg_rvalid && reg_rdata == 8'h00) else $error("hidden id visible");
    mfg_power_a: assert property (ce |=> mfg_id_power == $past(analog_control[MFG_READ_BIT]))
        else $error("id power wrong");

    // Amplifier control pin
    amp_off_a: assert property (ce && !amp_enable |=> !ext_amp_control_oe && !ext_amp_control_pin)
        else $error("amp pin active while disabled");
    amp_on_a: assert property (ce && amp_enable |=> ext_amp_control_oe) else $error("amp pin not enabled");
    amp_pol_a: assert property (ce && amp_enable
        |=> ext_amp_control_pin == ($past(amp_tx_active) ^ $past(amp_invert))) else $error("amp polarity wrong");

    // Soft reset, channel output and interrupt
    soft_reset_a: assert property (ce && soft_reset |=> analog_control == 8'h00 && channel == 7'h00
        && !wake_enable && wake_pending) else $error("soft reset incomplete");
    channel_out_a: assert property (ce |=> synth_channel == $past(channel)) else $error("channel not driven");
    irq_a: assert property (ce |=> wake_irq == ($past(wake_pending) && $past(wake_enable)))
        else $error("wake irq wrong");

    // Main scenarios reached
    wake_c: cover property (wake_event ##[1:20] wake_irq);
    status_read_c: cover property (reg_rd && reg_addr == WAKE_IRQ_STATUS_ADDR && wake_pending);
    cal_write_c: cover property (cal_bus.wr);
    amp_low_c: cover property (amp_enable && amp_invert);
    soft_reset_c: cover property (ce && soft_reset);

endmodule : radio_wake_analog_channel_regs

// File: radio_wake_analog_channel_regs_tb.sv
// Self-checking bench for the wake, analog control and channel registers
`timescale 1ns/100ps
module radio_wake_analog_channel_regs_tb;
    import radio_regs_pkg::*;
    // ==========================================================
    // Signals and counters
    localparam logic [31:0] ID = 32'hA1B2C3D4; // Arbitrary identity value
    logic clk; // System clock
    logic nrst; // Active-low reset
    logic ce; // Clock enable
    addr_type reg_addr; // Register address
    byte_type reg_wdata; // Write data
    logic reg_wr; // Write strobe
    logic reg_rd; // Read strobe
    byte_type reg_rdata; // Read data
    logic reg_rvalid; // Read data marker
    logic power_req; // Power request to the model
    logic power_down_pin; // Power-down level
    logic device_ready; // Readiness level
    logic [31:0] mfg_id; // Identity bytes
    logic amp_tx_active; // Transmit-active level
    logic mfg_id_power; // Identity block power
    logic ext_amp_control_pin; // Amplifier pin level
    logic ext_amp_control_oe; // Amplifier pin enable
    logic [6:0] synth_channel; // Channel output
    logic wake_irq; // Wake interrupt
    int n_mismatch; // Mismatches seen
    int checks_done; // Comparisons made
    int cycles; // Cycles since start

    // ==========================================================
    // Design and far side
    radio_wake_analog_channel_regs i_dut
    (
        .clk, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
        .power_down_pin, .device_ready, .mfg_id, .amp_tx_active, .mfg_id_power,
        .ext_amp_control_pin, .ext_amp_control_oe, .synth_channel, .wake_irq
    );
    radio_env_model #(.ID_VALUE(ID)) i_env
    (
        .clk, .nrst, .power_req, .power_down_pin, .device_ready, .mfg_id
    );

    // Clock at 100 ns period
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ==========================================================
    // Tasks
    // Compare two bytes and count
    task check(input byte_type got, input byte_type exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Wait edges, then step off the edge
    task tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : tick

    // One write on the register port, then an idle edge so the strobe never toggles twice at once
    task wr(input addr_type a, input byte_type d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask : wr

    // One read, waiting for the answer under a bound
    task rd(input addr_type a, input byte_type exp);
        int k;
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        k = 0;
        while (reg_rvalid !== 1'b1 && k < 8)
        begin
            tick(1);
            k++;
        end
        check({7'h00, reg_rvalid}, 8'h01);
        check(reg_rdata, exp);
    endtask : rd

    // Line at the end of each test
    task done(input string name);
        $display("test %s finished, mismatches %0d", name, n_mismatch);
    endtask : done

    // Counts, verdict and end of run
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // Cuts a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Test sequence
    initial
    begin
        cycles = 0;
        n_mismatch = 0;
        checks_done = 0;
        nrst = 1'b0;
        ce = 1'b1;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        power_req = 1'b0;
        amp_tx_active = 1'b0;
        tick(10);
        nrst = 1'b1;
        // Defaults, status clear on read, writes to status ignored
        rd(WAKE_IRQ_ENABLE_ADDR, 8'h00);
        rd(ANALOG_CONTROL_ADDR, 8'h00);
        rd(SYNTH_CHANNEL_ADDR, 8'h00);
        rd(WAKE_IRQ_STATUS_ADDR, 8'h01);
        rd(WAKE_IRQ_STATUS_ADDR, 8'h00);
        wr(WAKE_IRQ_STATUS_ADDR, 8'hFF);
        rd(WAKE_IRQ_STATUS_ADDR, 8'h00);
        rd(6'h30, 8'h00);
        done("reset");
        // Wake with source disabled, then enabled
        power_req = 1'b1;
        tick(8);
        rd(WAKE_IRQ_STATUS_ADDR, 8'h00);
        power_req = 1'b0;
        wr(WAKE_IRQ_ENABLE_ADDR, 8'h01);
        tick(2);
        power_req = 1'b1;
        tick(8);
        check({7'h00, wake_irq}, 8'h01);
        rd(WAKE_IRQ_STATUS_ADDR, 8'h01);
        tick(1);
        check({7'h00, wake_irq}, 8'h00);
        rd(WAKE_IRQ_STATUS_ADDR, 8'h00);
        done("wake");
        // Channel limits and clock-enable freeze
        wr(SYNTH_CHANNEL_ADDR, 8'h02);
        tick(1);
        check({1'b0, synth_channel}, 8'h02);
        wr(SYNTH_CHANNEL_ADDR, 8'h4F);
        tick(1);
        check({1'b0, synth_channel}, 8'h4F);
        ce = 1'b0;
        wr(SYNTH_CHANNEL_ADDR, 8'h10);
        ce = 1'b1;
        rd(SYNTH_CHANNEL_ADDR, 8'h4F);
        done("channel");
        // Calibration write lock
        wr(CAL_REG0_ADDR, 8'h5A);
        rd(CAL_REG0_ADDR, 8'h00);
        wr(ANALOG_CONTROL_ADDR, 8'h40);
        wr(CAL_REG0_ADDR, 8'h5A);
        wr(CAL_REG1_ADDR, 8'hA5);
        rd(CAL_REG0_ADDR, 8'h5A);
        rd(CAL_REG1_ADDR, 8'hA5);
        wr(ANALOG_CONTROL_ADDR, 8'h00);
        wr(CAL_REG1_ADDR, 8'h3C);
        rd(CAL_REG1_ADDR, 8'hA5);
        done("unlock");
        // Identity read gating
        rd(MFG_ID_FIRST_ADDR, 8'h00);
        wr(ANALOG_CONTROL_ADDR, 8'h20);
        tick(1);
        check({7'h00, mfg_id_power}, 8'h01);
        for (int i = 0; i < 4; i++)
            rd(MFG_ID_FIRST_ADDR + 6'(i), ID[8 * i +: 8]);
        wr(MFG_ID_FIRST_ADDR, 8'hFF);
        rd(MFG_ID_FIRST_ADDR, ID[7:0]);
        wr(ANALOG_CONTROL_ADDR, 8'h00);
        check({7'h00, mfg_id_power}, 8'h00);
        done("id");
        // Amplifier pin: enable, then polarity, each in its own write
        amp_tx_active = 1'b1;
        wr(ANALOG_CONTROL_ADDR, 8'h04);
        tick(1);
        check({6'h00, ext_amp_control_oe, ext_amp_control_pin}, 8'h03);
        wr(ANALOG_CONTROL_ADDR, 8'h06);
        tick(1);
        check({6'h00, ext_amp_control_oe, ext_amp_control_pin}, 8'h02);
        amp_tx_active = 1'b0;
        tick(2);
        check({6'h00, ext_amp_control_oe, ext_amp_control_pin}, 8'h03);
        wr(ANALOG_CONTROL_ADDR, 8'h02);
        tick(1);
        check({6'h00, ext_amp_control_oe, ext_amp_control_pin}, 8'h00);
        done("amp");
        // Soft reset restores every default
        wr(ANALOG_CONTROL_ADDR, 8'h42);
        wr(CAL_REG0_ADDR, 8'h77);
        wr(ANALOG_CONTROL_ADDR, 8'h01);
        tick(1);
        check({1'b0, synth_channel}, 8'h00);
        rd(ANALOG_CONTROL_ADDR, 8'h00);
        rd(SYNTH_CHANNEL_ADDR, 8'h00);
        rd(WAKE_IRQ_ENABLE_ADDR, 8'h00);
        rd(WAKE_IRQ_STATUS_ADDR, 8'h01);
        rd(CAL_REG0_ADDR, 8'h00);
        rd(CAL_REG1_ADDR, 8'h00);
        done("soft reset");
        report_and_stop();
    end
endmodule : radio_wake_analog_channel_regs_tb
